// File: rtl/fws_opnd_ram.sv
module fws_opnd_ram
  import fws_pkg::*;
#(
  parameter int WIDTH = 32,
  parameter int DEPTH = FWS_MAX_OPS,
  parameter int AW = 4
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] q;
  } fws_ram_t;

  fws_ram_t r;
  fws_ram_t next_r;

  // Write and registered read; read data hold until the next read
  always_comb begin
    next_r = r;
    if (wr_en) begin
      next_r.mem[wr_idx] = wr_data;
    end
    if (rd_en) begin
      next_r.q = r.mem[rd_idx];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rd_data = r.q;
endmodule

// File: rtl/fws_pkg.sv
package fws_pkg;
  // Register map, byte wide registers at their own addresses
  localparam logic [23:0] FWS_FCTL_ADDR = 24'h224000;
  localparam logic [23:0] FWS_ECTL_ADDR = 24'h224001;
  localparam logic [23:0] FWS_STAT0_ADDR = 24'h224002;
  localparam logic [23:0] FWS_STAT1_ADDR = 24'h224003;
  localparam logic [7:0] FWS_RST_BYTE = 8'h00;
  localparam logic [7:0] FWS_INVALID_BYTE = 8'hFF;

  // Control register fields
  localparam int FWS_START_BIT = 7;
  localparam int FWS_PAGE_BIT = 6;
  localparam int FWS_CHIP_BIT = 5;
  localparam int FWS_BYTE_BIT = 4;
  localparam int FWS_SECT_BIT = 3;
  localparam int FWS_PAUSE_BIT = 2;
  localparam int FWS_GUARD_BIT = 1;
  localparam int FWS_WFIS_BIT = 2;
  localparam int FWS_IEN_BIT = 1;

  // Status register fields
  localparam int FWS_ERR_BIT = 7;
  localparam int FWS_ERASE_FAIL_BIT = 7;
  localparam int FWS_PROG_FAIL_BIT = 6;
  localparam int FWS_SWAP_BIT = 5;

  // Sector status masks, test sector high down to F0 low
  localparam logic [6:0] FWS_SECT_TEST = 7'h40;
  localparam logic [6:0] FWS_SECT_E1 = 7'h20;
  localparam logic [6:0] FWS_SECT_E0 = 7'h10;
  localparam logic [6:0] FWS_SECT_F3 = 7'h08;
  localparam logic [6:0] FWS_SECT_F2 = 7'h04;
  localparam logic [6:0] FWS_SECT_F1 = 7'h02;
  localparam logic [6:0] FWS_SECT_F0 = 7'h01;
  localparam logic [6:0] FWS_SECT_FLASH = 7'h0F;
  localparam logic [6:0] FWS_SECT_EE = 7'h30;

  // Memory space decode
  localparam logic [23:0] FWS_EE_FIRST = 24'h220000;
  localparam logic [23:0] FWS_EE_LAST = 24'h2203FF;
  localparam logic [23:0] FWS_F1_FIRST = 24'h002000;
  localparam logic [23:0] FWS_F2_FIRST = 24'h004000;
  localparam logic [23:0] FWS_F3_FIRST = 24'h010000;
  localparam logic [23:0] FWS_FLASH_END = 24'h020000;
  localparam logic [23:0] FWS_TEST_FIRST = 24'h230000;
  localparam logic [23:0] FWS_TEST_LAST = 24'h231FFF;

  // Operand store
  localparam int FWS_MAX_OPS = 16;
  localparam logic [4:0] FWS_ONE = 5'h01;

  // Commands towards the cell engine
  typedef enum logic [2:0] {
    CMD_FETCH = 3'h0,
    CMD_PROG = 3'h1,
    CMD_SECT = 3'h2,
    CMD_CHIP = 3'h3,
    CMD_BUF = 3'h4,
    CMD_COPY = 3'h5,
    CMD_ERASE0 = 3'h6,
    CMD_EECHIP = 3'h7
  } fws_cmd_t;

  // Sequencer states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_LOAD = 6'h02,
    ST_READ = 6'h04,
    ST_PICK = 6'h08,
    ST_ISSUE = 6'h10,
    ST_SUSP = 6'h20
  } fws_state_t;
endpackage

// File: rtl/fws_sequencer.sv
module fws_sequencer
  import fws_pkg::*;
#(
  parameter int MAX_OPS = FWS_MAX_OPS
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [23:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [23:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_wr,
  input wire logic mem_rd,
  output logic [7:0] mem_rdata,
  input wire logic [7:0] arr_rdata,
  input wire logic ee_sector_e1,
  output logic eng_req,
  output logic [2:0] eng_cmd,
  output logic [23:0] eng_addr,
  output logic [7:0] eng_data,
  output logic eng_hold,
  input wire logic eng_ack,
  input wire logic [7:0] eng_old,
  input wire logic eng_erase_fail,
  input wire logic eng_prog_fail,
  input wire logic eng_swap_fail
);
  typedef struct packed {
    fws_state_t st;
    logic is_ee;
    logic fstart;
    logic [6:1] fsel;
    logic estart;
    logic [6:5] esel;
    logic wfis;
    logic ien;
    logic flash_in_progress;
    logic eeprom_in_progress;
    logic err;
    logic [6:0] sect;
    logic erase_fail;
    logic prog_fail;
    logic swap;
    logic [4:0] cnt;
    logic [3:0] idx;
    logic [19:0] page;
    fws_cmd_t cmd;
    logic req;
    logic hold;
    logic [23:0] eaddr;
    logic [7:0] edata;
    logic [7:0] rdata;
    logic [7:0] mdata;
  } fws_regs_t;

  fws_regs_t r;
  fws_regs_t next_r;
  logic ram_we;
  logic [3:0] ram_wi;
  logic [31:0] ram_wd;
  logic ram_re;
  logic [3:0] ram_ri;
  logic [31:0] ram_rd;

  // EEPROM window decode
  function automatic logic in_ee(input logic [23:0] a);
    in_ee = (a >= FWS_EE_FIRST) && (a <= FWS_EE_LAST);
  endfunction

  // Flash sector of an address, zero outside the flash sectors
  function automatic logic [6:0] flash_sector(input logic [23:0] a);
    if (a >= FWS_TEST_FIRST && a <= FWS_TEST_LAST) begin
      flash_sector = FWS_SECT_TEST;
    end else if (a < FWS_F1_FIRST) begin
      flash_sector = FWS_SECT_F0;
    end else if (a < FWS_F2_FIRST) begin
      flash_sector = FWS_SECT_F1;
    end else if (a < FWS_F3_FIRST) begin
      flash_sector = FWS_SECT_F2;
    end else if (a < FWS_FLASH_END) begin
      flash_sector = FWS_SECT_F3;
    end else begin
      flash_sector = 7'h00;
    end
  endfunction

  fws_opnd_ram #(
    .WIDTH(32),
    .DEPTH(MAX_OPS),
    .AW(4)
  ) u_opnd (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .wr_en(ram_we),
    .wr_idx(ram_wi),
    .wr_data(ram_wd),
    .rd_en(ram_re),
    .rd_idx(ram_ri),
    .rd_data(ram_rd)
  );

  always_comb begin
    logic go;
    logic fin;
    logic next_opnd;
    logic chip;
    logic page_op;
    logic [6:0] hit;
    go = 1'b0;
    fin = 1'b0;
    next_opnd = 1'b0;
    next_r = r;
    ram_we = 1'b0;
    ram_wi = r.cnt[3:0];
    ram_wd = {mem_addr, mem_wdata};
    ram_re = 1'b0;
    ram_ri = r.idx;
    chip = r.is_ee ? r.esel[FWS_CHIP_BIT] : r.fsel[FWS_CHIP_BIT];
    page_op = r.is_ee ? r.esel[FWS_PAGE_BIT] : r.fsel[FWS_PAGE_BIT];
    hit = ee_sector_e1 ? FWS_SECT_E1 : FWS_SECT_E0;

    // Register reads; data stand only in the cycle after the strobe
    next_r.rdata = FWS_RST_BYTE;
    if (reg_rd) begin
      unique case (reg_addr)
        FWS_FCTL_ADDR: next_r.rdata = {r.fstart, r.fsel, r.flash_in_progress};
        FWS_ECTL_ADDR: next_r.rdata = {r.estart, r.esel, 2'b00, r.wfis,
                                       r.ien, r.eeprom_in_progress};
        FWS_STAT0_ADDR: next_r.rdata = {r.err, r.sect};
        FWS_STAT1_ADDR: next_r.rdata = {r.erase_fail, r.prog_fail,
                                        r.swap, 5'h00};
        default: next_r.rdata = FWS_RST_BYTE;
      endcase
    end

    // Array reads see invalid data while that memory is busy
    next_r.mdata = FWS_RST_BYTE;
    if (mem_rd) begin
      if (in_ee(mem_addr) ? r.eeprom_in_progress : r.flash_in_progress) begin
        next_r.mdata = FWS_INVALID_BYTE;
      end else begin
        next_r.mdata = arr_rdata;
      end
    end

    // Software clear of the error flag takes the causes with it
    if (reg_wr && reg_addr == FWS_STAT0_ADDR && !reg_wdata[FWS_ERR_BIT]) begin
      next_r.err = 1'b0;
      next_r.erase_fail = 1'b0;
      next_r.prog_fail = 1'b0;
      next_r.swap = 1'b0;
    end

    // Flash control writes; the pause bit is always writable
    if (reg_wr && reg_addr == FWS_FCTL_ADDR) begin
      next_r.fsel[FWS_PAUSE_BIT] = reg_wdata[FWS_PAUSE_BIT];
      if (r.st == ST_IDLE) begin
        next_r.fsel = reg_wdata[6:1];
        if (reg_wdata[6:3] != 4'h0 || reg_wdata[FWS_GUARD_BIT]) begin
          next_r.st = ST_LOAD;
          next_r.is_ee = 1'b0;
          next_r.cnt = 5'h00;
          if (!r.err) begin
            next_r.sect = 7'h00;
          end
          go = reg_wdata[FWS_START_BIT];
        end
      end else if (r.st == ST_LOAD && !r.is_ee) begin
        next_r.fsel = reg_wdata[6:1];
        if (reg_wdata[6:3] == 4'h0 && !reg_wdata[FWS_GUARD_BIT]) begin
          next_r.st = ST_IDLE;
          next_r.cnt = 5'h00;
          next_r.flash_in_progress = 1'b0;
        end else begin
          go = reg_wdata[FWS_START_BIT];
        end
      end else if (r.st == ST_SUSP && !reg_wdata[FWS_PAUSE_BIT] &&
                   reg_wdata[FWS_START_BIT]) begin
        // Erase resume: request is still pending at the engine
        next_r.st = ST_ISSUE;
        next_r.hold = 1'b0;
        next_r.flash_in_progress = 1'b1;
        next_r.fstart = 1'b1;
      end
    end

    // EEPROM control writes; a zero start bit never aborts a run
    if (reg_wr && reg_addr == FWS_ECTL_ADDR) begin
      next_r.wfis = reg_wdata[FWS_WFIS_BIT];
      next_r.ien = reg_wdata[FWS_IEN_BIT];
      if (r.st == ST_IDLE) begin
        next_r.esel = reg_wdata[6:5];
        if (reg_wdata[6:5] != 2'b00) begin
          next_r.st = ST_LOAD;
          next_r.is_ee = 1'b1;
          next_r.cnt = 5'h00;
          if (!r.err) begin
            next_r.sect = 7'h00;
          end
          go = reg_wdata[FWS_START_BIT];
        end
      end else if (r.st == ST_LOAD && r.is_ee) begin
        next_r.esel = reg_wdata[6:5];
        if (reg_wdata[6:5] == 2'b00) begin
          next_r.st = ST_IDLE;
          next_r.cnt = 5'h00;
          next_r.eeprom_in_progress = 1'b0;
        end else begin
          go = reg_wdata[FWS_START_BIT];
        end
      end
    end

    // Stores into the selected memory space become operands
    if (mem_wr && r.st == ST_LOAD && in_ee(mem_addr) == r.is_ee &&
        r.cnt < 5'(MAX_OPS) && !chip) begin
      ram_we = 1'b1;
      next_r.cnt = r.cnt + FWS_ONE;
      next_r.page = mem_addr[23:4];
      if (r.is_ee) begin
        next_r.eeprom_in_progress = 1'b1;
        next_r.sect = next_r.sect | hit;
      end else begin
        next_r.flash_in_progress = 1'b1;
        next_r.sect = next_r.sect | flash_sector(mem_addr);
      end
    end

    // Launch, using the select bits as they stand after this write
    if (go) begin
      chip = (reg_addr == FWS_ECTL_ADDR) ? next_r.esel[FWS_CHIP_BIT] :
             next_r.fsel[FWS_CHIP_BIT]; // Not is_ee, stale in idle
      if (reg_addr == FWS_ECTL_ADDR) begin
        next_r.estart = 1'b1;
        next_r.eeprom_in_progress = 1'b1;
      end else begin
        next_r.fstart = 1'b1;
        next_r.flash_in_progress = 1'b1;
      end
      if (chip) begin
        next_r.st = ST_ISSUE;
        next_r.req = 1'b1;
        next_r.eaddr = 24'h000000;
        if (reg_addr == FWS_ECTL_ADDR) begin
          next_r.cmd = CMD_EECHIP;
          next_r.sect = next_r.sect | FWS_SECT_EE;
        end else begin
          next_r.cmd = CMD_CHIP;
          next_r.sect = next_r.sect | FWS_SECT_FLASH;
        end
      end else if (r.cnt == 5'h00) begin
        fin = 1'b1;
      end else begin
        next_r.st = ST_READ;
        next_r.idx = 4'h0;
      end
    end

    // Sequencer walk over the operands
    unique case (r.st)
      ST_IDLE, ST_LOAD, ST_SUSP: begin
      end
      ST_READ: begin
        ram_re = 1'b1;
        next_r.st = ST_PICK;
      end
      ST_PICK: begin
        next_r.edata = ram_rd[7:0];
        if (page_op) begin
          next_r.eaddr = {r.page, ram_rd[11:8]};
        end else begin
          next_r.eaddr = ram_rd[31:8];
        end
        if (r.is_ee) begin
          next_r.cmd = CMD_BUF;
        end else if (r.fsel[FWS_PAGE_BIT] || r.fsel[FWS_BYTE_BIT]) begin
          next_r.cmd = CMD_FETCH;
        end else if (r.fsel[FWS_SECT_BIT]) begin
          next_r.cmd = CMD_SECT;
        end else begin
          next_r.cmd = CMD_PROG;
        end
        next_r.req = 1'b1;
        next_r.st = ST_ISSUE;
      end
      ST_ISSUE: begin
        if (r.cmd == CMD_SECT && r.fsel[FWS_PAUSE_BIT] && !eng_ack) begin
          // Erase pause frees the flash for reads
          next_r.st = ST_SUSP;
          next_r.hold = 1'b1;
          next_r.flash_in_progress = 1'b0;
          next_r.fstart = 1'b0;
        end else if (eng_ack) begin
          next_r.req = 1'b0;
          if (eng_erase_fail) begin
            next_r.erase_fail = 1'b1;
            next_r.err = 1'b1;
          end
          if (eng_prog_fail) begin
            next_r.prog_fail = 1'b1;
            next_r.err = 1'b1;
          end
          if (eng_swap_fail && r.cmd == CMD_COPY) begin
            next_r.swap = 1'b1;
            next_r.err = 1'b1;
          end
          unique case (r.cmd)
            CMD_FETCH: begin
              if ((~eng_old & r.edata) != 8'h00) begin
                next_r.swap = 1'b1;
                next_r.err = 1'b1;
                next_opnd = 1'b1;
              end else begin
                next_r.cmd = CMD_PROG;
                next_r.req = 1'b1;
              end
            end
            CMD_COPY: begin
              if (eng_swap_fail) begin
                fin = 1'b1;
              end else begin
                next_r.cmd = CMD_ERASE0;
                next_r.req = 1'b1;
              end
            end
            CMD_CHIP, CMD_EECHIP, CMD_ERASE0: fin = 1'b1;
            CMD_PROG, CMD_SECT, CMD_BUF: next_opnd = 1'b1;
          endcase
        end
      end
      default: next_r.st = ST_IDLE;
    endcase

    // Step to the next operand, or the EEPROM swap tail
    if (next_opnd) begin
      if ({1'b0, r.idx} + FWS_ONE == r.cnt) begin
        if (r.is_ee) begin
          next_r.cmd = CMD_COPY;
          next_r.eaddr = {r.page, 4'h0};
          next_r.req = 1'b1;
        end else begin
          fin = 1'b1;
        end
      end else begin
        next_r.idx = r.idx + 4'h1;
        next_r.st = ST_READ;
      end
    end

    // Completion clears start and select bits by itself, except the flash pause bit
    if (fin) begin
      next_r.st = ST_IDLE;
      next_r.req = 1'b0;
      next_r.cnt = 5'h00;
      next_r.fsel = {5'h00, 1'b0} | {4'h0, next_r.fsel[FWS_PAUSE_BIT], 1'b0};
      next_r.esel = 2'b00;
      next_r.fstart = 1'b0;
      next_r.estart = 1'b0;
      next_r.flash_in_progress = 1'b0;
      next_r.eeprom_in_progress = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // All outputs straight from the state register
  assign reg_rdata = r.rdata;
  assign mem_rdata = r.mdata;
  assign eng_req = r.req;
  assign eng_cmd = r.cmd;
  assign eng_addr = r.eaddr;
  assign eng_data = r.edata;
  assign eng_hold = r.hold;
endmodule

// File: sim/fws_sequencer_assertions.sv
module fws_sequencer_assertions
  import fws_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic eng_req,
  input wire logic [2:0] eng_cmd,
  input wire logic [23:0] eng_addr,
  input wire logic [7:0] eng_data,
  input wire logic eng_hold,
  input wire logic eng_ack,
  input wire logic [7:0] eng_old,
  input wire logic eng_swap_fail
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Read data only in the cycle after a strobe
  chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("reg_rdata not zero outside read answer");
  chk_memrd_idle: assert property (!mem_rd |=> mem_rdata == 8'h00)
    else $error("mem_rdata not zero outside read answer");
  // Running flash op hides the array; suspend excluded as busy drops
  chk_memrd_busy: assert property (mem_rd && eng_req && !eng_hold &&
    eng_cmd < CMD_BUF && mem_addr < FWS_FLASH_END
    |=> mem_rdata == FWS_INVALID_BYTE)
    else $error("array read while busy not FFh");
  chk_req_hold: assert property (eng_req && !eng_ack |=> eng_req &&
    $stable(eng_cmd) && $stable(eng_addr) && $stable(eng_data))
    else $error("engine request changed before ack");
  chk_fetch_prog: assert property (eng_ack && eng_cmd == CMD_FETCH &&
    (eng_data & ~eng_old) == 8'h00
    |=> eng_req && eng_cmd == CMD_PROG && $stable(eng_addr))
    else $error("clean fetch not followed by program");
  chk_overwrite_skip: assert property (eng_ack && eng_cmd == CMD_FETCH &&
    (eng_data & ~eng_old) != 8'h00 |=> eng_cmd != CMD_PROG)
    else $error("zero to one byte was programmed");
  chk_swap_end: assert property (eng_ack && eng_cmd == CMD_COPY &&
    eng_swap_fail |=> !eng_req [*2])
    else $error("update went on after swap failure");
  chk_erase0_next: assert property (eng_ack && eng_cmd == CMD_COPY &&
    !eng_swap_fail |=> eng_req && eng_cmd == CMD_ERASE0)
    else $error("erase phase 0 missing after copy");
  chk_erase0_done: assert property (eng_ack && eng_cmd == CMD_ERASE0
    |=> !eng_req)
    else $error("update not finished after erase phase 0");
  chk_page_keep: assert property (eng_ack && eng_cmd == CMD_BUF
    |=> eng_cmd != CMD_BUF || eng_addr[23:4] == $past(eng_addr[23:4]))
    else $error("page address changed within update");

  cover property (eng_ack && eng_cmd == CMD_COPY && eng_swap_fail);
  cover property (eng_ack && eng_cmd == CMD_ERASE0);
  cover property (mem_rd && eng_req);
  cover property (eng_req && eng_hold);
endmodule

bind fws_sequencer fws_sequencer_assertions u_chk (.core_clk, .reset_n,
  .reg_rd, .reg_rdata, .mem_addr, .mem_rd, .mem_rdata, .eng_req, .eng_cmd,
  .eng_addr, .eng_data, .eng_hold, .eng_ack, .eng_old, .eng_swap_fail);

// File: sim/fws_sequencer_tb.sv
module fws_sequencer_tb import fws_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [23:0] reg_addr = 24'h0, mem_addr = 24'h0, eng_addr;
  logic [7:0] reg_wdata = 8'h0, mem_wdata = 8'h0, arr_rdata = 8'h0;
  logic [7:0] eng_old = 8'h0, reg_rdata, mem_rdata, eng_data, v, old_b;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mem_wr = 1'b0, mem_rd = 1'b0;
  logic ee_sector_e1 = 1'b0, eng_ack = 1'b0, eng_req, eng_hold;
  logic eng_erase_fail = 1'b0, eng_prog_fail = 1'b0, eng_swap_fail = 1'b0;
  logic [2:0] eng_cmd, fcmd, fk;
  logic [23:0] oa [16];
  logic [7:0] od [16];
  logic [34:0] log_q [$], exp_q [$];
  int miscompares = 0, total_checks = 0, seed = 32'h236D, dly = 0;

  always #2 core_clk = ~core_clk;

  fws_sequencer u_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata,
    .arr_rdata, .ee_sector_e1, .eng_req, .eng_cmd, .eng_addr, .eng_data,
    .eng_hold, .eng_ack, .eng_old, .eng_erase_fail, .eng_prog_fail,
    .eng_swap_fail);

  // Cell engine stand-in: slow random acks, failures on one chosen command
  // A paused erase gets no ack until software restarts it
  always @(posedge core_clk) begin
    eng_ack <= 1'b0;
    {eng_erase_fail, eng_prog_fail, eng_swap_fail} <= 3'h0;
    if (eng_req && !eng_ack && !eng_hold) begin
      if (dly > 0) dly = dly - 1;
      else begin
        eng_ack <= 1'b1;
        eng_old <= old_b;
        if (eng_cmd == fcmd) {eng_erase_fail, eng_prog_fail, eng_swap_fail} <= fk;
        log_q.push_back({eng_cmd, eng_addr, eng_data});
        dly = ($random(seed) & 32'h3) + 1;
      end
    end
  end

  task automatic chk(string nm, logic [39:0] seen, logic [39:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Register and array bus cycles, one-cycle strobes
  task automatic wr(logic [23:0] a, logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(string nm, logic [23:0] a, logic [7:0] m, logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
    chk(nm, v & m, e);
  endtask
  task automatic st(logic [23:0] a, logic [7:0] d);
    @(posedge core_clk);
    mem_addr <= a;
    mem_wdata <= d;
    mem_wr <= 1'b1;
    @(posedge core_clk);
    mem_wr <= 1'b0;
  endtask
  task automatic mrd(logic [23:0] a, logic [7:0] arr, logic [7:0] e);
    @(posedge core_clk);
    mem_addr <= a;
    arr_rdata <= arr;
    mem_rd <= 1'b1;
    @(posedge core_clk);
    mem_rd <= 1'b0;
    #1 chk("mem_rdata", mem_rdata, e);
  endtask
  task automatic ex(logic [2:0] c, logic [23:0] a, logic [7:0] d);
    exp_q.push_back({c, a, d});
  endtask

  // Select, load, start, optionally probe mid-run, then compare engine log
  task automatic op(logic [23:0] ctl, logic [7:0] sel, int n, bit probe,
                    logic [7:0] sect);
    logic [34:0] e, g;
    wr(ctl, sel);
    for (int i = 0; i < n; i++) st(oa[i], od[i]);
    wr(ctl, sel | 8'h80);
    if (probe) begin
      // Array read lands while the first engine request is out
      rchk("sector busy", FWS_STAT0_ADDR, 8'hFF, sect);
      mrd(oa[0], 8'h5A, FWS_INVALID_BYTE);
      wr(ctl, sel);
    end
    for (int k = 0; k < 300; k++) begin
      rchk("ctl poll", ctl, 8'h00, 8'h00);
      if (v[0] === 1'b0 && v[7] === 1'b0) break;
    end
    chk("ctl done", v, 8'h00);
    if (probe) mrd(oa[0], 8'h5A, 8'h5A);
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      g = (log_q.size() > 0) ? log_q.pop_front() : '1;
      if (e[34:32] inside {CMD_CHIP, CMD_COPY, CMD_ERASE0, CMD_EECHIP}) begin
        g[31:0] = 32'h0;
        e[31:0] = 32'h0;
      end
      chk("engine request", g, e);
    end
    chk("extra requests", log_q.size(), 0);
  endtask

  initial begin
    #100000;
    miscompares++;
    print_verdict;
  end

  initial begin
    old_b = 8'hFF;
    fcmd = 3'h0;
    fk = 3'h0;
    repeat (12) @(posedge core_clk);
    reset_n <= 1'b1;
    // Reset values, read-only cause register, unmapped address
    rchk("stat0 rst", FWS_STAT0_ADDR, 8'hFF, FWS_RST_BYTE);
    wr(FWS_STAT1_ADDR, 8'hFF);
    rchk("stat1 ro", FWS_STAT1_ADDR, 8'hFF, FWS_RST_BYTE);
    rchk("unmapped", 24'h224004, 8'hFF, 8'h00);
    // Page program over three pages; last page is the one used
    for (int i = 0; i < 3; i++) begin
      oa[i] = 24'h001000 + 24'(i * 17);
      od[i] = 8'($random(seed));
    end
    for (int i = 0; i < 3; i++) begin
      ex(CMD_FETCH, {oa[2][23:4], oa[i][3:0]}, od[i]);
      ex(CMD_PROG, {oa[2][23:4], oa[i][3:0]}, od[i]);
    end
    op(FWS_FCTL_ADDR, 8'h40, 3, 1, FWS_SECT_F0);
    rchk("stat1 ok", FWS_STAT1_ADDR, 8'hFF, 8'h00);
    // Byte program turning a zero into one: skipped, flagged
    old_b = 8'h00;
    oa[0] = 24'h003000;
    od[0] = 8'($random(seed)) | 8'h01;
    ex(CMD_FETCH, oa[0], od[0]);
    op(FWS_FCTL_ADDR, 8'h10, 1, 0, 8'h00);
    rchk("err f1", FWS_STAT0_ADDR, 8'hFF, 8'h80 | FWS_SECT_F1);
    rchk("swap", FWS_STAT1_ADDR, 8'hFF, 8'h20);
    wr(FWS_STAT0_ADDR, 8'hFF);
    rchk("stat0 ro", FWS_STAT0_ADDR, 8'hFF, 8'h80 | FWS_SECT_F1);
    wr(FWS_STAT0_ADDR, 8'h00);
    rchk("err clr", FWS_STAT0_ADDR, 8'h80, 8'h00);
    rchk("cause clr", FWS_STAT1_ADDR, 8'hFF, 8'h00);
    // Guard bits program without any overwrite check
    oa[0] = 24'h231FFC;
    od[0] = 8'h55;
    ex(CMD_PROG, oa[0], od[0]);
    op(FWS_FCTL_ADDR, 8'h02, 1, 0, 8'h00);
    rchk("guard", FWS_STAT1_ADDR, 8'hFF, 8'h00);
    // Program failure
    old_b = 8'hFF;
    fcmd = CMD_PROG;
    fk = 3'h2;
    oa[0] = 24'h00100F;
    ex(CMD_FETCH, oa[0], od[0]);
    ex(CMD_PROG, oa[0], od[0]);
    op(FWS_FCTL_ADDR, 8'h10, 1, 0, 8'h00);
    rchk("prog fail", FWS_STAT1_ADDR, 8'hFF, 8'h40);
    rchk("err prog", FWS_STAT0_ADDR, 8'h80, 8'h80);
    wr(FWS_STAT0_ADDR, 8'h00);
    // Two-sector erase with erase failure
    fcmd = CMD_SECT;
    fk = 3'h4;
    oa[0] = 24'h002100;
    oa[1] = 24'h010000;
    ex(CMD_SECT, oa[0], od[0]);
    ex(CMD_SECT, oa[1], od[1]);
    op(FWS_FCTL_ADDR, 8'h08, 2, 0, 8'h00);
    rchk("erase fail", FWS_STAT1_ADDR, 8'hFF, 8'h80);
    rchk("err sect", FWS_STAT0_ADDR, 8'hFF, 8'h8A);
    wr(FWS_STAT0_ADDR, 8'h00);
    rchk("cause clr2", FWS_STAT1_ADDR, 8'hFF, 8'h00);
    // Cancel before start discards the latched operand
    fk = 3'h0;
    oa[0] = 24'h001000;
    wr(FWS_FCTL_ADDR, 8'h10);
    st(oa[0], od[0]);
    rchk("busy load", FWS_FCTL_ADDR, 8'hFF, 8'h11);
    wr(FWS_FCTL_ADDR, 8'h00);
    rchk("cancel", FWS_FCTL_ADDR, 8'hFF, 8'h00);
    op(FWS_FCTL_ADDR, 8'h10, 0, 0, 8'h00);
    // Erase pause frees the array; the restart inside op finishes it
    oa[0] = 24'h002100;
    ex(CMD_SECT, oa[0], od[0]);
    wr(FWS_FCTL_ADDR, 8'h08);
    st(oa[0], od[0]);
    wr(FWS_FCTL_ADDR, 8'h88);
    wr(FWS_FCTL_ADDR, 8'h0C);
    rchk("paused ctl", FWS_FCTL_ADDR, 8'hFF, 8'h0C);
    rchk("paused sect", FWS_STAT0_ADDR, 8'hFF, FWS_SECT_F1);
    mrd(oa[0], 8'h5A, 8'h5A);
    op(FWS_FCTL_ADDR, 8'h08, 0, 0, 8'h00);
    // EEPROM updates: swap failure, then clean with mid-run start clear
    for (int j = 0; j < 2; j++) begin
      ee_sector_e1 <= j[0];
      fcmd = CMD_COPY;
      fk = j ? 3'h0 : 3'h1;
      for (int i = 0; i < 3; i++) begin
        oa[i] = 24'h220020 + 24'(i * 5);
        od[i] = 8'($random(seed));
        ex(CMD_BUF, oa[i], od[i]);
      end
      ex(CMD_COPY, 24'h0, 8'h0);
      if (j) ex(CMD_ERASE0, 24'h0, 8'h0);
      op(FWS_ECTL_ADDR, 8'h40, 3, j[0], FWS_SECT_E1);
      rchk("ee swap", FWS_STAT1_ADDR, 8'hFF, j ? 8'h00 : 8'h20);
      if (!j) rchk("ee err", FWS_STAT0_ADDR, 8'hFF, 8'h90);
      wr(FWS_STAT0_ADDR, 8'h00);
    end
    // Flash and EEPROM chip erase, no operands
    // Flash one selects and starts in one write, right after an EEPROM run
    for (int j = 0; j < 2; j++) begin
      ex(j ? CMD_EECHIP : CMD_CHIP, 24'h0, 8'h0);
      op(j ? FWS_ECTL_ADDR : FWS_FCTL_ADDR, j ? 8'h20 : 8'hA0, 0, 0,
         8'h00);
    end
    print_verdict;
  end
endmodule
